// file: swa_cmd.v
`timescale 1ns/1ps
`include "swa_regs.vh"
module swa_cmd #(
  parameter GUARD_CYC = `SWA_GUARD_CYC,
  parameter [47:0] LOCAL_ADDR = 48'h0012_3456_789A // arbitrary value
) (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire uart_rx,
  output reg uart_tx,
  input wire cts_n,
  output reg rts_n,
  input wire [7:0] radio_rx_data,
  input wire radio_rx_valid,
  output wire radio_rx_ready,
  output reg [7:0] radio_tx_data,
  output reg radio_tx_valid,
  input wire link_up,
  output reg connect_stb,
  output reg [47:0] peer_addr,
  output reg svc_dun,
  output reg clear_stb,
  output reg radio_rst_stb,
  output reg nv_wr_stb,
  output wire [31:0] nv_data,
  output wire [7:0] pio_out,
  output wire [7:0] pio_oe
);
  // ==========================================================
  // ascii codes
  localparam [7:0] CH_CR = 8'h0D, CH_LF = 8'h0A, CH_SP = 8'h20, CH_CM = 8'h2C;
  localparam [7:0] CH_0 = 8'h30, CH_1 = 8'h31, CH_2 = 8'h32, CH_3 = 8'h33;
  localparam [7:0] CH_5 = 8'h35, CH_7 = 8'h37, CH_A = 8'h41, CH_C = 8'h43;
  localparam [7:0] CH_D = 8'h44, CH_E = 8'h45, CH_F = 8'h46, CH_I = 8'h49;
  localparam [7:0] CH_K = 8'h4B, CH_L = 8'h4C, CH_M = 8'h4D, CH_N = 8'h4E;
  localparam [7:0] CH_O = 8'h4F, CH_R = 8'h52, CH_S = 8'h53, CH_T = 8'h54;
  localparam [7:0] CH_U = 8'h55, CH_W = 8'h57;
  localparam [31:0] BIT_FULL = `SWA_BIT_CYC; // full-width timing counts
  localparam [31:0] HALF_FULL = `SWA_HALF_CYC;
  localparam [10:0] BIT_CYC = BIT_FULL[10:0];
  localparam [10:0] HALF_CYC = HALF_FULL[10:0];

  // ==========================================================
  // helpers
  function [4:0] hexv; // {valid, nibble}
    input [7:0] c;
    begin
      if (c >= CH_0 && c <= 8'h39) hexv = {1'b1, c[3:0]};
      else if (c >= CH_A && c <= CH_F) hexv = {1'b1, c[3:0] + 4'h9};
      else hexv = 5'h00;
    end
  endfunction
  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'hA) ? {4'h3, n} : {4'h4, n - 4'h9};
    end
  endfunction
  function isbit;
    input [7:0] c;
    begin
      isbit = (c == CH_0) || (c == CH_1);
    end
  endfunction

  // ==========================================================
  // state
  reg [31:0] cfg_r; // role, data mode, profile, pins
  reg [47:0] laddr_r; // local wireless address
  reg [1:0] mode_r;
  reg rep_busy_r, rep_remote_r; // reply in progress, reply goes to the peer
  reg link_d_r; // link edge detect
  reg rx_m_r, rx_s_r, cts_m_r, cts_s_r; // pin synchronisers
  wire flow_en = ~(cfg_r[11] & cfg_r[19]);
  assign pio_oe = cfg_r[15:8];
  assign pio_out = cfg_r[23:16];
  assign nv_data = cfg_r;

  // ==========================================================
  // apb slave, zero wait, data latched in setup phase
  wire setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  reg map_hit;
  reg [31:0] rd_mux;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~map_hit; // unmapped address
  always @* begin
    map_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `SWA_CFG_OFS: rd_mux = cfg_r;
      `SWA_STAT_OFS: rd_mux = {26'h0, rep_busy_r, ~flow_en, link_up, 1'b0, mode_r};
      `SWA_LADDR_LO_OFS: rd_mux = laddr_r[31:0];
      `SWA_LADDR_HI_OFS: rd_mux = {16'h0000, laddr_r[47:32]};
      `SWA_PEER_LO_OFS: rd_mux = peer_addr[31:0];
      `SWA_PEER_HI_OFS: rd_mux = {16'h0000, peer_addr[47:32]};
      `SWA_NVSTORE_OFS: rd_mux = 32'h0000_0000;
      default: map_hit = 1'b0;
    endcase
  end
  // read data held from the setup cycle through the access phase
  always @(posedge clk) begin
    if (reset) prdata <= 32'h0000_0000;
    else if (setup) prdata <= rd_mux;
  end

  // ==========================================================
  // uart receiver, 8N1, mid-bit sampling
  reg [1:0] rxs_r; // 0 idle, 1 start, 2 data, 3 stop
  reg [10:0] rxc_r;
  reg [2:0] rxn_r;
  reg [7:0] rxsh_r;
  reg rx_stb;
  always @(posedge clk) begin
    if (reset) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      cts_m_r <= 1'b1;
      cts_s_r <= 1'b1;
      rxs_r <= 2'h0;
      rxc_r <= 11'h000;
      rxn_r <= 3'h0;
      rxsh_r <= 8'h00;
      rx_stb <= 1'b0;
    end else begin
      rx_m_r <= uart_rx;
      rx_s_r <= rx_m_r;
      cts_m_r <= cts_n;
      cts_s_r <= cts_m_r;
      rx_stb <= 1'b0;
      rxc_r <= rxc_r - 11'h001;
      case (rxs_r)
        2'h0: if (!rx_s_r) begin
          rxs_r <= 2'h1;
          rxc_r <= HALF_CYC;
        end
        2'h1: if (rxc_r == 11'h000) begin
          // glitch shorter than half a bit is dropped
          rxs_r <= rx_s_r ? 2'h0 : 2'h2;
          rxc_r <= BIT_CYC - 11'h001;
          rxn_r <= 3'h0;
        end
        2'h2: if (rxc_r == 11'h000) begin
          rxsh_r <= {rx_s_r, rxsh_r[7:1]};
          rxc_r <= BIT_CYC - 11'h001;
          rxn_r <= rxn_r + 3'h1;
          if (rxn_r == 3'h7) rxs_r <= 2'h3;
        end
        2'h3: if (rxc_r == 11'h000) begin
          rxs_r <= 2'h0;
          rx_stb <= rx_s_r; // framing error drops byte
        end
        default: rxs_r <= 2'h0;
      endcase
    end
  end

  // ==========================================================
  // reply engine and uart transmitter
  reg tx_loc_r; // byte on the wire is local reply text
  reg [2:0] rep_kind_r;
  reg [5:0] rep_idx_r;
  reg [8:0] rep_b; // {last, byte}
  reg [9:0] txsh_r;
  reg [3:0] txn_r;
  reg [10:0] txc_r;
  wire tx_idle = (txn_r == 4'h0);
  wire flow_ok = ~flow_en | ~cts_s_r;
  wire rep_local = rep_busy_r & ~rep_remote_r;
  assign radio_rx_ready = tx_idle & flow_ok & ~rep_local & ~reset;
  // reply text, every reply framed by CR LF
  always @* begin
    rep_b = {1'b0, CH_CR};
    if (rep_idx_r == 6'h1) rep_b = {1'b0, CH_LF};
    case (rep_kind_r)
      `SWA_REP_OK: case (rep_idx_r)
        6'h2: rep_b = {1'b0, CH_O};
        6'h3: rep_b = {1'b0, CH_K};
        6'h5: rep_b = {1'b1, CH_LF};
        default: ;
      endcase
      `SWA_REP_ERR: case (rep_idx_r)
        6'h2: rep_b = {1'b0, CH_E};
        6'h3, 6'h4, 6'h6: rep_b = {1'b0, CH_R};
        6'h5: rep_b = {1'b0, CH_O};
        6'h8: rep_b = {1'b1, CH_LF};
        default: ;
      endcase
      `SWA_REP_ADDR: begin
        if (rep_idx_r >= 6'h2 && rep_idx_r <= 6'hD)
          rep_b = {1'b0, hexc(laddr_r[47 - 4 * (rep_idx_r - 6'h2) -: 4])};
        case (rep_idx_r)
          6'hF, 6'h13: rep_b = {rep_idx_r == 6'h13, CH_LF};
          6'h10: rep_b = {1'b0, CH_O};
          6'h11: rep_b = {1'b0, CH_K};
          default: ;
        endcase
      end
      `SWA_REP_CFG: case (rep_idx_r)
        6'h2: rep_b = {1'b0, 7'h18, cfg_r[`SWA_CFG_ROLE]};
        6'h4: rep_b = {1'b0, 7'h18, cfg_r[`SWA_CFG_DMODE]};
        6'h6: rep_b = {1'b0, CH_0};
        6'h8: rep_b = {1'b0, 7'h18, cfg_r[`SWA_CFG_PROF]};
        6'h3, 6'h5, 6'h7: rep_b = {1'b0, CH_CM};
        6'hA: rep_b = {1'b1, CH_LF};
        default: ;
      endcase
      default: begin // connect: OK then CONNECT,addr
        if (rep_idx_r >= 6'h10 && rep_idx_r <= 6'h1B)
          rep_b = {1'b0, hexc(peer_addr[47 - 4 * (rep_idx_r - 6'h10) -: 4])};
        case (rep_idx_r)
          6'h2, 6'h9: rep_b = {1'b0, CH_O};
          6'h3: rep_b = {1'b0, CH_K};
          6'h5, 6'h7, 6'h1D: rep_b = {rep_idx_r == 6'h1D, CH_LF};
          6'h8, 6'hD: rep_b = {1'b0, CH_C};
          6'hA, 6'hB: rep_b = {1'b0, CH_N};
          6'hC: rep_b = {1'b0, CH_E};
          6'hE: rep_b = {1'b0, CH_T};
          6'hF: rep_b = {1'b0, CH_CM};
          default: ;
        endcase
      end
    endcase
  end
  // local rx byte goes to the parser or out as payload
  wire local_cmd = (mode_r == `SWA_MODE_CMD) | ~link_up;
  wire pay_out = rx_stb & ~local_cmd;
  wire rem_take = radio_rx_valid & radio_rx_ready;
  wire rem_cmd = rem_take & (mode_r == `SWA_MODE_FAST) & cfg_r[`SWA_CFG_ROLE] & link_up;
  wire rep_go = rep_busy_r & (rep_remote_r ? ~pay_out : (tx_idle & flow_ok));
  wire tx_go = rep_go & ~rep_remote_r | rem_take;
  wire [7:0] tx_byte = rep_local ? rep_b[7:0] : radio_rx_data;
  // serial shift out; only reply text or peer payload, never an echo
  always @(posedge clk) begin
    if (reset) begin
      txsh_r <= 10'h3FF;
      txn_r <= 4'h0;
      txc_r <= 11'h000;
      uart_tx <= 1'b1;
      tx_loc_r <= 1'b0;
    end else if (tx_go) begin
      txsh_r <= {1'b1, tx_byte, 1'b0};
      // one extra step so the stop bit lasts a full bit time
      txn_r <= 4'hB;
      txc_r <= 11'h000;
      tx_loc_r <= rep_local;
    end else if (!tx_idle) begin
      if (txc_r == 11'h000) begin
        uart_tx <= txsh_r[0];
        txsh_r <= {1'b1, txsh_r[9:1]};
        txn_r <= txn_r - 4'h1;
        txc_r <= BIT_CYC - 11'h001;
      end else txc_r <= txc_r - 11'h001;
    end
  end

  // ==========================================================
  // command line buffer and decode
  reg [7:0] buf_r [0:23];
  reg [4:0] n_r;
  reg ovf_r;
  wire p_stb = (rx_stb & local_cmd & ~rep_busy_r) | rem_cmd;
  wire [7:0] rx_m_byte = rxsh_r;
  wire [7:0] p_raw = rem_cmd ? radio_rx_data : rx_m_byte;
  wire [7:0] p_byte = (p_raw >= 8'h61 && p_raw <= 8'h7A) ? p_raw - 8'h20 : p_raw;
  reg [3:0] dc;
  reg [47:0] dm_addr;
  reg hx_ok;
  reg [4:0] hv;
  integer k;
  // decode at line end
  always @* begin
    dc = `SWA_C_BAD;
    hx_ok = 1'b1;
    dm_addr = 48'h0;
    hv = 5'h00;
    for (k = 0; k < 12; k = k + 1) begin
      hv = hexv(buf_r[5 + k]);
      dm_addr[47 - 4 * k -: 4] = hv[3:0];
      hx_ok = hx_ok & hv[4];
    end
    if (!ovf_r && n_r >= 5'h2 && buf_r[0] == CH_A && buf_r[1] == CH_T) case (n_r)
      5'h02: dc = `SWA_C_AT;
      5'h04: if (buf_r[2] == CH_M) begin
        if (buf_r[3] == CH_C) dc = `SWA_C_MC;
        if (buf_r[3] == CH_D) dc = `SWA_C_MD;
        if (buf_r[3] == CH_F) dc = `SWA_C_MF;
      end
      5'h05: if (buf_r[2] == CH_U && buf_r[3] == CH_C && buf_r[4] == CH_L) dc = `SWA_C_CL;
      5'h06: begin
        if (buf_r[2] == CH_U && buf_r[3] == CH_R && buf_r[4] == CH_S && buf_r[5] == CH_T)
          dc = `SWA_C_RST;
        if (buf_r[2] == CH_S && buf_r[3] == CH_I && buf_r[4] == CH_CM) begin
          if (buf_r[5] == CH_1) dc = `SWA_C_SI1;
          if (buf_r[5] == CH_7) dc = `SWA_C_SI7;
        end
      end
      5'h0C: if (buf_r[2] == CH_S && buf_r[3] == CH_W && buf_r[4] == CH_2 &&
                 buf_r[6] == CH_CM && buf_r[8] == CH_CM && buf_r[10] == CH_CM &&
                 buf_r[7] >= CH_0 && buf_r[7] <= CH_7 && isbit(buf_r[9]) &&
                 isbit(buf_r[11])) begin
        if (buf_r[5] == CH_2) dc = `SWA_C_PDIR;
        if (buf_r[5] == CH_3) dc = `SWA_C_PLVL;
      end
      5'h0E: if (buf_r[2] == CH_S && buf_r[3] == CH_W && buf_r[4] == CH_2 &&
                 buf_r[5] == CH_5 && buf_r[6] == CH_CM && buf_r[8] == CH_CM &&
                 buf_r[10] == CH_CM && buf_r[12] == CH_CM && isbit(buf_r[7]) &&
                 isbit(buf_r[9]) && buf_r[11] == CH_0 && isbit(buf_r[13]))
        dc = `SWA_C_ROLE;
      5'h16: if (buf_r[2] == CH_D && buf_r[3] == CH_M && buf_r[4] == CH_CM &&
                 buf_r[17] == CH_CM && hx_ok && buf_r[18] == CH_1 &&
                 buf_r[19] == CH_1 && buf_r[20] == CH_0 &&
                 (buf_r[21] == CH_1 || buf_r[21] == CH_3))
        dc = `SWA_C_DM;
      default: dc = `SWA_C_BAD;
    endcase
  end

  // ==========================================================
  // escape detector: idle, escape line, idle
  reg [19:0] idle_r;
  reg [2:0] esc_r;
  reg esc_pend_r;
  wire guard_ok = (idle_r >= GUARD_CYC);
  reg [7:0] esc_ch;
  always @* begin
    case (esc_r)
      3'h0: esc_ch = CH_A;
      3'h1: esc_ch = CH_T;
      3'h2: esc_ch = CH_M;
      3'h3: esc_ch = CH_C;
      3'h4: esc_ch = CH_CR;
      default: esc_ch = CH_LF;
    endcase
  end

  // ==========================================================
  // main control: buffer, modes, configuration, reply start
  reg [1:0] post_r; // after reply: 1 restart, 2 enter data
  wire [2:0] pin = buf_r[7][2:0];
  always @(posedge clk) begin
    if (reset) begin
      cfg_r <= `SWA_CFG_RST; // slave, auto accept
      laddr_r <= LOCAL_ADDR;
      mode_r <= `SWA_MODE_DATA;
      link_d_r <= 1'b0;
      n_r <= 5'h00;
      ovf_r <= 1'b0;
      rep_busy_r <= 1'b0;
      rep_remote_r <= 1'b0;
      rep_kind_r <= `SWA_REP_OK;
      rep_idx_r <= 6'h00;
      post_r <= 2'h0;
      idle_r <= 20'h0;
      esc_r <= 3'h0;
      esc_pend_r <= 1'b0;
      peer_addr <= 48'h0;
      svc_dun <= 1'b0;
      connect_stb <= 1'b0;
      clear_stb <= 1'b0;
      radio_rst_stb <= 1'b0;
      nv_wr_stb <= 1'b0;
      radio_tx_valid <= 1'b0;
      radio_tx_data <= 8'h00;
      rts_n <= 1'b1;
    end else begin
      connect_stb <= 1'b0;
      clear_stb <= 1'b0;
      radio_rst_stb <= 1'b0;
      nv_wr_stb <= 1'b0;
      radio_tx_valid <= 1'b0;
      link_d_r <= link_up;
      // hold host off until the last reply byte has left the wire
      rts_n <= flow_en & (rep_local | (tx_loc_r & ~tx_idle));
      // software access, setting applies at once
      if (apb_wr) case (paddr)
        `SWA_CFG_OFS: cfg_r <= {8'h00, pwdata[23:8], 5'h00, pwdata[2:0]};
        `SWA_LADDR_LO_OFS: laddr_r[31:0] <= pwdata;
        `SWA_LADDR_HI_OFS: laddr_r[47:32] <= pwdata[15:0];
        `SWA_NVSTORE_OFS: nv_wr_stb <= pwdata[0];
        default: ;
      endcase
      // incoming connection picks mode from configuration
      if (link_up && !link_d_r && mode_r != `SWA_MODE_CMD)
        mode_r <= cfg_r[`SWA_CFG_DMODE] ? `SWA_MODE_DATA : `SWA_MODE_FAST;
      // payload to the peer
      if (pay_out) begin
        radio_tx_valid <= 1'b1;
        radio_tx_data <= rx_m_byte;
      end
      // escape tracking on the payload stream
      if (rx_stb) idle_r <= 20'h0;
      else if (!guard_ok) idle_r <= idle_r + 20'h1;
      if (pay_out) begin
        esc_pend_r <= 1'b0;
        if (rx_m_byte == esc_ch && (esc_r != 3'h0 || guard_ok))
          esc_r <= (esc_r == 3'h5) ? 3'h0 : esc_r + 3'h1;
        else esc_r <= 3'h0;
        if (esc_r == 3'h5 && rx_m_byte == CH_LF) esc_pend_r <= 1'b1;
      end else if (esc_pend_r && guard_ok && !rep_busy_r) begin
        esc_pend_r <= 1'b0;
        mode_r <= `SWA_MODE_CMD;
        rep_busy_r <= 1'b1;
        rep_remote_r <= 1'b0;
        rep_kind_r <= `SWA_REP_OK;
        rep_idx_r <= 6'h00;
      end
      // reply bytes
      if (rep_go) begin
        if (rep_remote_r) begin
          radio_tx_valid <= 1'b1;
          radio_tx_data <= rep_b[7:0];
        end
        rep_idx_r <= rep_idx_r + 6'h01;
        if (rep_b[8]) begin
          rep_busy_r <= 1'b0;
          post_r <= 2'h0;
          if (post_r == 2'h1) begin
            radio_rst_stb <= 1'b1;
            mode_r <= `SWA_MODE_DATA;
          end
          if (post_r == 2'h2) mode_r <= `SWA_MODE_DATA;
        end
      end
      // line assembly; spaces and CR are not stored
      if (p_stb && p_byte != CH_LF) begin
        if (p_byte != CH_CR && p_byte != CH_SP) begin
          if (n_r == `SWA_BUF_LEN) ovf_r <= 1'b1;
          else begin
            buf_r[n_r] <= p_byte;
            n_r <= n_r + 5'h01;
          end
        end
      end else if (p_stb) begin
        n_r <= 5'h00;
        ovf_r <= 1'b0;
        rep_busy_r <= (dc != `SWA_C_BAD) | ~rem_cmd; // remote errors stay silent
        rep_remote_r <= rem_cmd;
        rep_idx_r <= 6'h00;
        rep_kind_r <= `SWA_REP_OK;
        case (dc)
          `SWA_C_AT: ;
          `SWA_C_MC: mode_r <= `SWA_MODE_CMD;
          `SWA_C_MD: mode_r <= `SWA_MODE_DATA;
          `SWA_C_MF: mode_r <= `SWA_MODE_FAST;
          `SWA_C_RST: post_r <= 2'h1;
          // a fast connection survives the clear
          `SWA_C_CL: clear_stb <= ~(link_up & mode_r == `SWA_MODE_FAST);
          `SWA_C_ROLE: begin
            cfg_r[`SWA_CFG_ROLE] <= buf_r[7][0];
            cfg_r[`SWA_CFG_DMODE] <= buf_r[9][0];
            cfg_r[`SWA_CFG_PROF] <= buf_r[13][0];
          end
          `SWA_C_PDIR: begin
            cfg_r[8 + pin] <= buf_r[9][0];
            nv_wr_stb <= buf_r[11][0];
          end
          `SWA_C_PLVL: begin
            cfg_r[16 + pin] <= buf_r[9][0];
            nv_wr_stb <= buf_r[11][0];
          end
          `SWA_C_SI1: rep_kind_r <= `SWA_REP_ADDR;
          `SWA_C_SI7: rep_kind_r <= `SWA_REP_CFG;
          `SWA_C_DM: begin
            peer_addr <= dm_addr;
            svc_dun <= buf_r[21][1];
            connect_stb <= 1'b1;
            rep_kind_r <= `SWA_REP_CONN;
            post_r <= 2'h2;
          end
          default: rep_kind_r <= `SWA_REP_ERR;
        endcase
      end
    end
  end
endmodule

// file: swa_cmd_properties.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the command block
module swa_cmd_properties (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire uart_tx,
  input wire rts_n,
  input wire radio_rx_ready,
  input wire radio_tx_valid,
  input wire link_up,
  input wire nv_wr_stb,
  input wire [31:0] nv_data,
  input wire [7:0] pio_out,
  input wire [7:0] pio_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // start bit while no peer: must be local reply text
  sequence local_tx_start;
    $fell(uart_tx) ##0 !link_up;
  endsequence
  // write of the store trigger with bit 0 set
  sequence store_write;
    psel && penable && pwrite && paddr == 8'h18 && pwdata[0];
  endsequence
  a_reset_idle: assert property ($fell(reset) |-> uart_tx && rts_n && !nv_wr_stb)
    else $error("outputs not idle after reset");
  a_cfg_default: assert property ($fell(reset) |-> nv_data == 32'h0000_0002)
    else $error("config not at default after reset");
  a_start_bit: assert property ($fell(uart_tx) |=> (!uart_tx) [*8])
    else $error("start bit too short");
  a_no_echo: assert property (local_tx_start |-> rts_n || (pio_oe[3] && pio_out[3]))
    else $error("serial output outside a reply");
  a_store_pulse: assert property (store_write |=> nv_wr_stb ##1 !nv_wr_stb)
    else $error("store strobe not a single pulse");
  a_pin_mirror: assert property (nv_data[15:8] == pio_oe && nv_data[23:16] == pio_out)
    else $error("pin outputs differ from stored config");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr && pready)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h18 |=> prdata == 0)
    else $error("unmapped read data not zero");
  a_rx_gate: assert property (radio_rx_ready |-> uart_tx)
    else $error("payload accepted while serial busy");
  a_tx_pulse: assert property (radio_tx_valid |=> !radio_tx_valid)
    else $error("radio byte strobe longer than one cycle");
endmodule
bind swa_cmd swa_cmd_properties u_props (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .uart_tx(uart_tx), .rts_n(rts_n),
  .radio_rx_ready(radio_rx_ready), .radio_tx_valid(radio_tx_valid), .link_up(link_up),
  .nv_wr_stb(nv_wr_stb), .nv_data(nv_data), .pio_out(pio_out), .pio_oe(pio_oe));

// file: swa_cmd_test.sv
`timescale 1ns/1ps
// ==========================================
// bench for the command block
module swa_cmd_test;
  logic clk, reset, psel, penable, pwrite, radio_rx_valid, link_up;
  logic [7:0] paddr, radio_rx_data;
  logic [31:0] pwdata, r;
  logic e;
  wire [31:0] prdata, nv_data;
  wire pready, pslverr, uart_rx, uart_tx, cts_n, rts_n, radio_rx_ready, radio_tx_valid;
  wire nv_wr_stb;
  wire [7:0] radio_tx_data, pio_out, pio_oe;
  integer n_mismatch = 0;
  integer checked = 0;
  // short guard keeps escape timing cheap
  swa_cmd #(.GUARD_CYC(200)) DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .uart_rx(uart_rx), .uart_tx(uart_tx), .cts_n(cts_n), .rts_n(rts_n),
    .radio_rx_data(radio_rx_data), .radio_rx_valid(radio_rx_valid),
    .radio_rx_ready(radio_rx_ready), .radio_tx_data(radio_tx_data),
    .radio_tx_valid(radio_tx_valid), .link_up(link_up), .connect_stb(), .peer_addr(),
    .svc_dun(), .clear_stb(), .radio_rst_stb(), .nv_wr_stb(nv_wr_stb), .nv_data(nv_data),
    .pio_out(pio_out), .pio_oe(pio_oe));
  swa_host_model host (.clk(clk), .ser_out(uart_rx), .ser_in(uart_tx), .cts_n(cts_n));
  // ==========================================
  // shared tasks
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_up;
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up;
  endtask
  // apb: setup, then access until pready at an edge
  task apb(input [7:0] a, input w, input [31:0] d);
    integer k;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'h1 && k < 20);
    if (pready !== 1'h1) give_up;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // bounded wait for reply bytes
  task wait_rx(input integer n, input integer lim);
    integer k;
    k = 0;
    while (host.rx_q.size() < n && k < lim) begin @(posedge clk); k++; end
    if (host.rx_q.size() < n) give_up;
  endtask
  // ==========================================
  // scenarios
  task t_regs;
    apb(8'h00, 1'h0, 32'h0); chk(r, 32'h0000_0002);
    apb(8'h04, 1'h0, 32'h0); chk(r[4:0], 5'h01);
    apb(8'h08, 1'h1, 32'hA5C3_5A3C);
    apb(8'h08, 1'h0, 32'h0); chk(r, 32'hA5C3_5A3C);
    apb(8'h1C, 1'h1, 32'hFFFF_FFFF); chk(e, 1'h1);
    apb(8'h1C, 1'h0, 32'h0); chk(r, 32'h0);
    apb(8'h18, 1'h1, 32'h1);
    #1 chk(nv_wr_stb, 1'h1);
    $display("register test done");
  endtask
  // pin 3 needs both output and high to drop flow control
  task t_flow;
    apb(8'h00, 1'h1, 32'h0008_0802);
    apb(8'h04, 1'h0, 32'h0); chk(r[4], 1'h1);
    chk({pio_oe[3], pio_out[3]}, 2'h3);
    apb(8'h00, 1'h1, 32'h0008_0002);
    apb(8'h04, 1'h0, 32'h0); chk(r[4], 1'h0);
    apb(8'h00, 1'h1, 32'h0000_0002);
    $display("flow test done");
  endtask
  // payload both ways while the peer is up
  task t_data;
    integer k;
    @(posedge clk);
    link_up <= 1'h1;
    radio_rx_data <= 8'h5A;
    radio_rx_valid <= 1'h1;
    k = 0;
    do begin @(posedge clk); k++; end while (radio_rx_ready !== 1'h1 && k < 200);
    if (radio_rx_ready !== 1'h1) give_up;
    radio_rx_valid <= 1'h0;
    wait_rx(1, 15000);
    chk(host.rx_q.pop_front(), 8'h5A);
    fork host.send(8'h3C); join_none
    k = 0;
    do begin @(posedge clk); k++; end while (radio_tx_valid !== 1'h1 && k < 15000);
    if (radio_tx_valid !== 1'h1) give_up;
    chk(radio_tx_valid, 1'h1);
    chk(radio_tx_data, 8'h3C);
    repeat (1041) @(posedge clk);
    link_up <= 1'h0;
    $display("data test done");
  endtask
  // bare attention with no peer, no escape first
  task t_at;
    logic [7:0] exp [6] = '{8'h0D, 8'h0A, 8'h4F, 8'h4B, 8'h0D, 8'h0A};
    integer i;
    host.rx_q.delete();
    host.set_cts(1'h1);
    host.send(8'h41);
    host.send(8'h54);
    host.send(8'h0D);
    host.send(8'h0A);
    repeat (4) @(posedge clk);
    chk({uart_tx, rts_n}, 2'h3);
    chk(host.rx_q.size(), 0);
    host.set_cts(1'h0);
    wait_rx(6, 70000);
    for (i = 0; i < 6; i++) chk(host.rx_q[i], exp[i]);
    chk(host.rx_q.size(), 6);
    $display("attention test done");
  endtask
  // ==========================================
  // clock, reset and main sequence
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    radio_rx_data = 8'h0;
    radio_rx_valid = 1'h0;
    link_up = 1'h0;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    t_regs;
    t_flow;
    t_data;
    t_at;
    wrap_up;
  end
endmodule

// file: swa_host_model.sv
`timescale 1ns/1ps
`include "swa_regs.vh"
// ==========================================
// host terminal: 8N1 at the default rate
module swa_host_model (
  input wire clk,
  output logic ser_out,
  input wire ser_in,
  output logic cts_n
);
  localparam integer BIT = `SWA_BIT_CYC; // clocks per bit
  logic [7:0] rx_q[$]; // bytes caught from the device
  logic [7:0] got; // receiver shift bits
  integer i;
  // idle mark, clear to send until set_cts raises the hold-off line
  initial begin
    ser_out = 1'h1;
    cts_n = 1'h0;
  end
  // hold-off line: high stops the device sending
  task set_cts(input v);
    @(posedge clk);
    cts_n <= v;
  endtask
  // one frame: start, eight bits lsb first, one stop
  task send(input [7:0] b);
    integer j;
    @(posedge clk);
    ser_out <= 1'h0;
    for (j = 0; j < 9; j++) begin
      repeat (BIT) @(posedge clk);
      ser_out <= (j < 8) ? b[j] : 1'h1;
    end
    repeat (BIT) @(posedge clk);
  endtask
  // receiver samples mid-bit; a bad stop bit yields unknown data
  initial begin
    forever begin
      @(negedge ser_in);
      repeat (BIT / 2) @(posedge clk);
      for (i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk);
        got[i] = ser_in;
      end
      repeat (BIT) @(posedge clk);
      rx_q.push_back((ser_in === 1'h1) ? got : 8'hxx);
    end
  end
endmodule

// file: swa_regs.vh
`ifndef SWA_REGS_VH
`define SWA_REGS_VH
// ==========================================================
// timing
`define SWA_CLK_HZ 10000000
`define SWA_BAUD 9600
`define SWA_BIT_CYC (`SWA_CLK_HZ / `SWA_BAUD)
`define SWA_HALF_CYC (`SWA_BIT_CYC / 2)
`define SWA_GUARD_MS 50
`define SWA_GUARD_CYC (`SWA_GUARD_MS * (`SWA_CLK_HZ / 1000))
// ==========================================================
// register byte offsets
`define SWA_CFG_OFS 8'h00
`define SWA_STAT_OFS 8'h04
`define SWA_LADDR_LO_OFS 8'h08
`define SWA_LADDR_HI_OFS 8'h0C
`define SWA_PEER_LO_OFS 8'h10
`define SWA_PEER_HI_OFS 8'h14
`define SWA_NVSTORE_OFS 8'h18
// cfg fields: [0] role, [1] data mode, [2] profile, [15:8] dir, [23:16] level
`define SWA_CFG_ROLE 0
`define SWA_CFG_DMODE 1
`define SWA_CFG_PROF 2
`define SWA_CFG_RST 32'h0000_0002
// ==========================================================
// modes
`define SWA_MODE_CMD 2'h0
`define SWA_MODE_DATA 2'h1
`define SWA_MODE_FAST 2'h2
// reply kinds
`define SWA_REP_OK 3'h0
`define SWA_REP_ERR 3'h1
`define SWA_REP_ADDR 3'h2
`define SWA_REP_CFG 3'h3
`define SWA_REP_CONN 3'h4
// command codes
`define SWA_C_BAD 4'h0
`define SWA_C_AT 4'h1
`define SWA_C_MC 4'h2
`define SWA_C_MD 4'h3
`define SWA_C_MF 4'h4
`define SWA_C_RST 4'h5
`define SWA_C_CL 4'h6
`define SWA_C_ROLE 4'h7
`define SWA_C_PDIR 4'h8
`define SWA_C_PLVL 4'h9
`define SWA_C_SI1 4'hA
`define SWA_C_SI7 4'hB
`define SWA_C_DM 4'hC
// command line buffer depth
`define SWA_BUF_LEN 5'h18
`endif
